// file: logic/ckc_config.sv
// Summary of operation
// - Bits 27:24 divide VCO for 48 MHz domain; codes 0 and 1 invalid.
// - Bit 22 picks internal or external fast oscillator; writable only both PLLs off.
// - Bits 17:16 divide VCO by 2, 4, 6 or 8 for PLL output.
// - System output divider writable only while main PLL is off.
// - Bits 14:6 multiply VCO input; only 192 to 432 are valid.
// - Multiplier written only with main PLL off and by half-word or word.
// - Bits 5:0 divide PLL source before VCO; codes 0 and 1 invalid.
// - Input divider writable only while both PLLs are off.
// - Clock configuration accesses wait one or two cycles during a clock switch.
// - Bits 31:30 select clock out B source: system, audio PLL, external, PLL.
// - Bits 29:27 prescale clock out B: 0xx undivided, 1xx divide 2 to 5.
// - Bits 26:24 prescale clock out A with the same coding.
// - Bit 23 picks audio PLL or external pin for audio serial clock.
// - Bits 22:21 select clock out A: internal, slow external, fast external, PLL.
// - Bits 20:16 divide external fast oscillator for RTC; 0 and 1 no clock.
// - Bits 15:13 prescale high APB clock: 0xx undivided, 1xx by 2 to 16.
// - Bits 12:10 prescale low APB clock with the same coding.
// - New APB ratio takes effect 1 to 16 AHB cycles after the write.
// - Bits 3:2 read back the active system clock source.
// - Bits 1:0 select the system clock; code 11 is not allowed.
// - Bits 7:4 prescale AHB clock: 0xxx undivided, 1xxx by 2 to 512.
`timescale 1ns/1ns
module ckc_config (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [ckc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ckc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       internal_fast_osc,
	input  wire logic                       external_fast_osc,
	input  wire logic                       external_slow_osc,
	input  wire logic                       main_pll_vco,
	input  wire logic                       audio_pll_clock,
	input  wire logic                       audio_ext_clock_pin,
	input  wire logic                       main_pll_on,
	input  wire logic                       audio_pll_on,
	output logic                            pll_source_select,
	output logic [5:0]                      pll_input_divider,
	output logic [8:0]                      vco_multiplier,
	output logic                            pll_config_error,
	output logic                            pll_general_clock,
	output logic                            fortyeight_mhz_clock,
	output logic                            audio_serial_clock,
	output logic                            clock_out_a,
	output logic                            clock_out_b,
	output logic                            rtc_clock,
	output logic                            system_clock,
	output logic                            ahb_clock,
	output logic                            apb_high_clock,
	output logic                            apb_low_clock,
	output logic [1:0]                      switch_status
);
	import ckc_pkg::*;

	logic [31:0]        pll_configuration;
	logic [31:0]        clock_configuration;
	logic [ADDR_W-1:0]  wr_addr;
	logic [31:0]        wr_data;
	logic [3:0]         wr_strb;
	logic               aw_have;
	logic               w_have;
	logic [ADDR_W-1:0]  rd_addr;
	logic               ar_have;
	logic               wr_blocked;
	logic               rd_blocked;
	logic               wr_go;
	logic               rd_go;
	ckc_switch_t        switch_state;
	logic [1:0]         switch_cnt;
	logic [1:0]         switch_select;
	logic [31:0]        next_pll;
	logic [31:0]        pll_mask;
	logic [31:0]        next_clk;
	logic [31:0]        pll_read;
	logic [31:0]        clk_read;
	logic [3:0]         fortyeight_mhz_divider;
	logic [1:0]         system_output_divider;
	logic [1:0]         clock_out_b_source;
	logic [2:0]         clock_out_b_prescaler;
	logic [2:0]         clock_out_a_prescaler;
	logic               audio_clock_source;
	logic [1:0]         clock_out_a_source;
	logic [4:0]         rtc_divider;
	logic [2:0]         apb_high_prescaler;
	logic [2:0]         apb_low_prescaler;
	logic [3:0]         ahb_prescaler;
	logic               system_src;

	// Field views
	assign fortyeight_mhz_divider = pll_configuration[Q_LSB +: 4];
	assign pll_source_select      = pll_configuration[SRC_BIT];
	assign system_output_divider  = pll_configuration[P_LSB +: 2];
	assign vco_multiplier         = pll_configuration[N_LSB +: 9];
	assign pll_input_divider      = pll_configuration[M_LSB +: 6];
	assign clock_out_b_source     = clock_configuration[OUTB_SRC_LSB +: 2];
	assign clock_out_b_prescaler  = clock_configuration[OUTB_PRE_LSB +: 3];
	assign clock_out_a_prescaler  = clock_configuration[OUTA_PRE_LSB +: 3];
	assign audio_clock_source     = clock_configuration[AUDIO_BIT];
	assign clock_out_a_source     = clock_configuration[OUTA_SRC_LSB +: 2];
	assign rtc_divider            = clock_configuration[RTC_LSB +: 5];
	assign apb_high_prescaler     = clock_configuration[APB_HI_LSB +: 3];
	assign apb_low_prescaler      = clock_configuration[APB_LO_LSB +: 3];
	assign ahb_prescaler          = clock_configuration[AHB_LSB +: 4];
	assign switch_select          = clock_configuration[SW_LSB +: 2];

	// Reserved bits read their reset value
	assign pll_read = (pll_configuration & PLL_CFG_WR_MASK) | (PLL_CFG_RESET & ~PLL_CFG_WR_MASK);
	assign clk_read = (clock_configuration & CLK_CFG_WR_MASK) | {28'h0, switch_status, 2'h0}
		| (CLK_CFG_RESET & ~CLK_CFG_WR_MASK);

	// Invalid divider or multiplier codes
	always_ff @(posedge clk) begin
		if (rst) begin
			pll_config_error <= 1'b0;
		end else begin
			pll_config_error <= (fortyeight_mhz_divider < Q_MIN)
				| (vco_multiplier < N_MIN) | (vco_multiplier > N_MAX)
				| (pll_input_divider < M_MIN);
		end
	end

	// Write channel handshake; address and data taken in either order
	assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_have & ~s_axi_bvalid;
	assign wr_blocked    = (wr_addr == CLK_CFG_OFFSET) && (switch_state == SWITCH_BUSY);
	assign wr_go         = aw_have & w_have & ~wr_blocked;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have <= 1'b0;
			wr_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have <= 1'b1;
			wr_addr <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			w_have  <= 1'b0;
			wr_data <= '0;
			wr_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have  <= 1'b1;
			wr_data <= s_axi_wdata;
			wr_strb <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (wr_addr == PLL_CFG_OFFSET || wr_addr == CLK_CFG_OFFSET) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Locking of PLL fields while the PLLs run
	always_comb begin
		next_pll = ckc_merge(pll_configuration, wr_data, wr_strb);
		pll_mask = PLL_CFG_WR_MASK;
		if (main_pll_on || audio_pll_on) begin
			pll_mask = pll_mask & ~(SRC_MASK | M_MASK);
		end
		if (main_pll_on) begin
			pll_mask = pll_mask & ~(P_MASK | N_MASK | Q_MASK);
		end
		if (wr_strb[1:0] != 2'h3) begin
			pll_mask = pll_mask & ~N_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pll_configuration <= PLL_CFG_RESET;
		end else if (wr_go && wr_addr == PLL_CFG_OFFSET) begin
			pll_configuration <= (pll_configuration & ~pll_mask) | (next_pll & pll_mask);
		end
	end

	// Clock configuration write; a forbidden switch code keeps the old selection
	always_comb begin
		next_clk = ckc_merge(clock_configuration, wr_data, wr_strb) & CLK_CFG_WR_MASK;
		if (next_clk[SW_LSB +: 2] == SW_NOT_ALLOWED) begin
			next_clk[SW_LSB +: 2] = switch_select;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			clock_configuration <= CLK_CFG_RESET;
		end else if (wr_go && wr_addr == CLK_CFG_OFFSET) begin
			clock_configuration <= next_clk;
		end
	end

	// Read channel
	assign s_axi_arready = ~ar_have & ~s_axi_rvalid;
	assign rd_blocked    = (rd_addr == CLK_CFG_OFFSET) && (switch_state == SWITCH_BUSY);
	assign rd_go         = ar_have & ~rd_blocked;

	always_ff @(posedge clk) begin
		if (rst) begin
			ar_have <= 1'b0;
			rd_addr <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			ar_have <= 1'b1;
			rd_addr <= s_axi_araddr;
		end else if (rd_go) begin
			ar_have <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			if (rd_addr == PLL_CFG_OFFSET) begin
				s_axi_rdata <= pll_read;
				s_axi_rresp <= RESP_OKAY;
			end else if (rd_addr == CLK_CFG_OFFSET) begin
				s_axi_rdata <= clk_read;
				s_axi_rresp <= RESP_OKAY;
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// System clock switch sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			switch_state  <= SWITCH_IDLE;
			switch_cnt    <= '0;
			switch_status <= 2'h0;
		end else begin
			case (switch_state)
				SWITCH_IDLE: begin
					if (switch_select != switch_status) begin
						switch_state <= SWITCH_BUSY;
						switch_cnt   <= SWITCH_CYCLES - 2'h1;
					end
				end
				SWITCH_BUSY: begin
					if (switch_cnt == 2'h0) begin
						switch_state  <= SWITCH_IDLE;
						switch_status <= switch_select;
					end else begin
						switch_cnt <= switch_cnt - 2'h1;
					end
				end
				default: switch_state <= SWITCH_IDLE;
			endcase
		end
	end

	// System clock source
	always_ff @(posedge clk) begin
		if (rst) begin
			system_src <= 1'b0;
		end else begin
			case (switch_status)
				2'h0: system_src <= internal_fast_osc;
				2'h1: system_src <= external_fast_osc;
				default: system_src <= pll_general_clock;
			endcase
		end
	end

	assign system_clock = system_src;

	always_ff @(posedge clk) begin
		if (rst) begin
			audio_serial_clock <= 1'b0;
		end else begin
			audio_serial_clock <= audio_clock_source ? audio_ext_clock_pin : audio_pll_clock;
		end
	end

	// PLL output dividers: system 2, 4, 6, 8 from code 0 to 3; 48 MHz divides by its code, codes 0 and 1 give no clock
	ckc_divider u_out_div (
		.clk     (clk),
		.rst     (rst),
		.src     (main_pll_vco),
		.ratio   (RATIO_W'({system_output_divider, 1'b0}) + RATIO_W'(2)),
		.clk_out (pll_general_clock)
	);

	ckc_divider u_q_div (
		.clk     (clk),
		.rst     (rst),
		.src     (main_pll_vco),
		.ratio   ((fortyeight_mhz_divider < Q_MIN) ? RATIO_W'(0) : RATIO_W'(fortyeight_mhz_divider)),
		.clk_out (fortyeight_mhz_clock)
	);

	ckc_divider u_rtc_div (
		.clk     (clk),
		.rst     (rst),
		.src     (external_fast_osc),
		.ratio   ((rtc_divider < 5'h2) ? RATIO_W'(0) : RATIO_W'(rtc_divider)),
		.clk_out (rtc_clock)
	);

	ckc_divider u_ahb_div (
		.clk     (clk),
		.rst     (rst),
		.src     (system_src),
		.ratio   (ckc_ahb_ratio(ahb_prescaler)),
		.clk_out (ahb_clock)
	);

	// Ratio reloads at period end, at most 16 AHB cycles later
	ckc_divider u_apb_high (
		.clk     (clk),
		.rst     (rst),
		.src     (ahb_clock),
		.ratio   (ckc_apb_ratio(apb_high_prescaler)),
		.clk_out (apb_high_clock)
	);

	ckc_divider u_apb_low (
		.clk     (clk),
		.rst     (rst),
		.src     (ahb_clock),
		.ratio   (ckc_apb_ratio(apb_low_prescaler)),
		.clk_out (apb_low_clock)
	);

	ckc_clock_out u_out_a (
		.clk           (clk),
		.rst           (rst),
		.source_select (clock_out_a_source),
		.prescaler     (clock_out_a_prescaler),
		.src0          (internal_fast_osc),
		.src1          (external_slow_osc),
		.src2          (external_fast_osc),
		.src3          (pll_general_clock),
		.clk_out       (clock_out_a)
	);

	ckc_clock_out u_out_b (
		.clk           (clk),
		.rst           (rst),
		.source_select (clock_out_b_source),
		.prescaler     (clock_out_b_prescaler),
		.src0          (system_src),
		.src1          (audio_pll_clock),
		.src2          (external_fast_osc),
		.src3          (pll_general_clock),
		.clk_out       (clock_out_b)
	);

endmodule

// file: logic/ckc_pkg.sv
package ckc_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int RATIO_W = 10;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] PLL_CFG_OFFSET = 4'h4;
	localparam logic [ADDR_W-1:0] CLK_CFG_OFFSET = 4'h8;

	// Reset values
	localparam logic [31:0] PLL_CFG_RESET = 32'h24003010;
	localparam logic [31:0] CLK_CFG_RESET = 32'h00000000;

	// Writable bits; all other bits hold their reset value
	localparam logic [31:0] PLL_CFG_WR_MASK = 32'h0f437fff;
	localparam logic [31:0] CLK_CFG_WR_MASK = 32'hfffffcf3;

	// Pll configuration fields
	localparam int Q_LSB    = 24;
	localparam int SRC_BIT  = 22;
	localparam int P_LSB    = 16;
	localparam int N_LSB    = 6;
	localparam int M_LSB    = 0;
	localparam logic [31:0] Q_MASK   = 32'h0f000000;
	localparam logic [31:0] SRC_MASK = 32'h00400000;
	localparam logic [31:0] P_MASK   = 32'h00030000;
	localparam logic [31:0] N_MASK   = 32'h00007fc0;
	localparam logic [31:0] M_MASK   = 32'h0000003f;
	localparam logic [8:0]  N_MIN    = 9'h0c0;
	localparam logic [8:0]  N_MAX    = 9'h1b0;
	localparam logic [5:0]  M_MIN    = 6'h02;
	localparam logic [3:0]  Q_MIN    = 4'h2;

	// Clock configuration fields
	localparam int OUTB_SRC_LSB = 30;
	localparam int OUTB_PRE_LSB = 27;
	localparam int OUTA_PRE_LSB = 24;
	localparam int AUDIO_BIT    = 23;
	localparam int OUTA_SRC_LSB = 21;
	localparam int RTC_LSB      = 16;
	localparam int APB_HI_LSB   = 13;
	localparam int APB_LO_LSB   = 10;
	localparam int AHB_LSB      = 4;
	localparam int SWS_LSB      = 2;
	localparam int SW_LSB       = 0;
	localparam logic [1:0] SW_NOT_ALLOWED = 2'h3;

	// System clock switch takes this many cycles; clock configuration accesses wait meanwhile
	localparam logic [1:0] SWITCH_CYCLES = 2'h2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {
		SWITCH_IDLE,
		SWITCH_BUSY
	} ckc_switch_t;

	function automatic logic [31:0] ckc_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [RATIO_W-1:0] ckc_out_pre_ratio(input logic [2:0] code);
		return code[2] ? RATIO_W'({code[1:0]} + 3'h2) : RATIO_W'(1);
	endfunction

	function automatic logic [RATIO_W-1:0] ckc_apb_ratio(input logic [2:0] code);
		return code[2] ? (RATIO_W'(2) << code[1:0]) : RATIO_W'(1);
	endfunction

	function automatic logic [RATIO_W-1:0] ckc_ahb_ratio(input logic [3:0] code);
		logic [RATIO_W-1:0] r;
		r = RATIO_W'(1);
		if (code[3]) begin
			r = (code[2:0] < 3'h4) ? (RATIO_W'(2) << code[1:0]) : (RATIO_W'(64) << code[1:0]);
		end
		return r;
	endfunction

endpackage

// file: logic/ckc_divider.sv
`timescale 1ns/1ns
module ckc_divider (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        src,
	input  wire logic [ckc_pkg::RATIO_W-1:0] ratio,
	output logic                             clk_out
);
	import ckc_pkg::*;

	logic                 src_q;
	logic [RATIO_W-1:0]   cnt;
	logic [RATIO_W-1:0]   cur;
	logic                 rise;

	assign rise = src & ~src_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			src_q <= 1'b0;
		end else begin
			src_q <= src;
		end
	end

	// New ratio taken only at a period boundary, so no short pulse appears
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
			cur <= RATIO_W'(1);
		end else if (rise) begin
			if (cnt + RATIO_W'(1) >= cur) begin
				cnt <= '0;
				cur <= ratio;
			end else begin
				cnt <= cnt + RATIO_W'(1);
			end
		end
	end

	// Ratio 0 gives no clock, ratio 1 passes the source through
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_out <= 1'b0;
		end else if (cur == '0) begin
			clk_out <= 1'b0;
		end else if (cur == RATIO_W'(1)) begin
			clk_out <= src;
		end else begin
			clk_out <= (cnt < (cur >> 1));
		end
	end

endmodule

// file: logic/ckc_clock_out.sv
`timescale 1ns/1ns
module ckc_clock_out (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [1:0] source_select,
	input  wire logic [2:0] prescaler,
	input  wire logic       src0,
	input  wire logic       src1,
	input  wire logic       src2,
	input  wire logic       src3,
	output logic            clk_out
);
	import ckc_pkg::*;

	logic selected;

	// Output pin source multiplexer
	always_ff @(posedge clk) begin
		if (rst) begin
			selected <= 1'b0;
		end else begin
			case (source_select)
				2'h0: selected <= src0;
				2'h1: selected <= src1;
				2'h2: selected <= src2;
				default: selected <= src3;
			endcase
		end
	end

	ckc_divider u_pre (
		.clk     (clk),
		.rst     (rst),
		.src     (selected),
		.ratio   (ckc_out_pre_ratio(prescaler)),
		.clk_out (clk_out)
	);

endmodule

// file: tb/ckc_config_asserts.sv
`timescale 1ns/1ns
module ckc_config_asserts (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       main_pll_on,
	input wire logic       audio_pll_on,
	input wire logic       pll_source_select,
	input wire logic [5:0] pll_input_divider,
	input wire logic [8:0] vco_multiplier,
	input wire logic       pll_config_error,
	input wire logic [1:0] switch_status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Write address and data taken together
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bvalid or bresp dropped before bready");
	a_write_answer: assert property (s_wr_taken |-> ##[1:4] s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_rd_taken |-> ##[1:4] s_axi_rvalid)
		else $error("read response late");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	a_mult_locked: assert property ($past(main_pll_on) |-> $stable(vco_multiplier))
		else $error("multiplier changed with main pll on");
	a_input_locked: assert property ($past(main_pll_on || audio_pll_on) |->
		$stable(pll_input_divider) && $stable(pll_source_select))
		else $error("input divider or source changed with a pll on");
	a_error_flag: assert property ($past(vco_multiplier) > 9'h1b0 || $past(vco_multiplier) < 9'h0c0 ||
		$past(pll_input_divider) < 6'h02 |-> pll_config_error)
		else $error("bad pll setting not flagged");
	a_status_legal: assert property (switch_status != 2'h3)
		else $error("switch status shows illegal source");
endmodule

bind ckc_config ckc_config_asserts u_chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .main_pll_on, .audio_pll_on, .pll_source_select, .pll_input_divider,
	.vco_multiplier, .pll_config_error, .switch_status);

// file: tb/tb_pll_and_clock_divider_config.sv
`timescale 1ns/1ns
module tb_pll_and_clock_divider_config;
	import ckc_pkg::*;
	logic        clk = 0;
	logic        rst = 1;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, switch_status;
	logic        main_pll_on = 0, audio_pll_on = 0, pll_source_select, pll_config_error;
	logic [5:0]  pll_input_divider;
	logic [8:0]  vco_multiplier;
	logic [4:0]  osc = 5'h0;
	int          fails = 0;
	int          tests_run = 0;
	logic [31:0] rd;
	logic [1:0]  resp;
	wire  [9:0]  clks;

	always #4 clk = ~clk;
	// Slow source clocks derived from a free counter
	always @(posedge clk) osc <= osc + 5'h1;

	ckc_config uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.internal_fast_osc(osc[1]), .external_fast_osc(osc[2]), .external_slow_osc(osc[4]),
		.main_pll_vco(osc[1]), .audio_pll_clock(osc[3]), .audio_ext_clock_pin(osc[2]), .main_pll_on,
		.audio_pll_on, .pll_source_select, .pll_input_divider, .vco_multiplier, .pll_config_error,
		.pll_general_clock(clks[0]), .fortyeight_mhz_clock(clks[1]), .audio_serial_clock(clks[2]),
		.clock_out_a(clks[3]), .clock_out_b(clks[4]), .rtc_clock(clks[5]), .system_clock(clks[6]),
		.ahb_clock(clks[7]), .apb_high_clock(clks[8]), .apb_low_clock(clks[9]), .switch_status);

	task automatic conclude();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1;
				s_axi_awvalid <= 0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1;
				s_axi_wvalid <= 0;
			end
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask

	task automatic axi_read(input logic [3:0] a);
		logic ar_done;
		ar_done = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk);
			if (!ar_done && s_axi_arready === 1'b1) begin
				ar_done = 1;
				s_axi_arvalid <= 0;
			end
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	task automatic t_reset();
		axi_read(PLL_CFG_OFFSET);
		check("pll_configuration", rd, 32'h24003010);
		axi_read(CLK_CFG_OFFSET);
		check("clock_configuration", rd, 32'h00000000);
		check("vco_multiplier", 32'(vco_multiplier), 32'h000000c0);
		check("pll_input_divider", 32'(pll_input_divider), 32'h00000010);
		check("pll_config_error", 32'(pll_config_error), 32'h0);
		$display("test reset done");
	endtask

	task automatic t_pll_write();
		axi_write(PLL_CFG_OFFSET, 32'hffffffff, 4'hf);
		check("bresp", 32'(resp), 32'h0);
		axi_read(PLL_CFG_OFFSET);
		check("pll_configuration", rd, 32'h2f437fff);
		check("vco_multiplier", 32'(vco_multiplier), 32'h000001ff);
		check("pll_source_select", 32'(pll_source_select), 32'h1);
		check("pll_config_error", 32'(pll_config_error), 32'h1);
		$display("test pll write done");
	endtask

	task automatic t_pll_lock();
		main_pll_on <= 1;
		axi_write(PLL_CFG_OFFSET, 32'h0, 4'hf);
		axi_read(PLL_CFG_OFFSET);
		check("locked by main pll", rd, 32'h2f437fff);
		main_pll_on <= 0;
		audio_pll_on <= 1;
		axi_write(PLL_CFG_OFFSET, 32'h0, 4'hf);
		axi_read(PLL_CFG_OFFSET);
		check("locked by audio pll", rd, 32'h2040003f);
		audio_pll_on <= 0;
		$display("test pll lock done");
	endtask

	task automatic t_byte_write();
		axi_write(PLL_CFG_OFFSET, 32'h000000c5, 4'h1);
		axi_read(PLL_CFG_OFFSET);
		check("byte write", rd, 32'h20400005);
		axi_write(PLL_CFG_OFFSET, 32'h00003005, 4'h3);
		axi_read(PLL_CFG_OFFSET);
		check("half word write", rd, 32'h20403005);
		check("vco_multiplier", 32'(vco_multiplier), 32'h000000c0);
		axi_write(PLL_CFG_OFFSET, 32'h02403010, 4'hf);
		repeat (2) @(posedge clk);
		check("pll_config_error", 32'(pll_config_error), 32'h0);
		$display("test byte write done");
	endtask

	// Counts rising edges of every derived clock over a window that is a multiple of all periods
	task automatic t_clocks();
		int         n[10];
		logic [9:0] prev;
		axi_write(CLK_CFG_OFFSET, 32'h60459400, 4'hf);
		repeat (64) @(posedge clk);
		prev = clks;
		repeat (320) begin
			@(posedge clk);
			for (int i = 0; i < 10; i++) begin
				if (clks[i] && !prev[i]) begin
					n[i]++;
				end
			end
			prev = clks;
		end
		check("pll_general_clock rises", n[0], 40);
		check("fortyeight_mhz_clock rises", n[1], 40);
		check("audio_serial_clock rises", n[2], 20);
		check("clock_out_a rises", n[3], 40);
		check("clock_out_b rises", n[4], 10);
		check("rtc_clock rises", n[5], 8);
		check("system_clock rises", n[6], 80);
		check("ahb_clock rises", n[7], 80);
		check("apb_high_clock rises", n[8], 40);
		check("apb_low_clock rises", n[9], 20);
		$display("test clocks done");
	endtask

	task automatic t_clk_cfg();
		axi_write(CLK_CFG_OFFSET, 32'hffffffff, 4'hf);
		axi_read(CLK_CFG_OFFSET);
		check("clock_configuration", rd, 32'hfffffcf0);
		axi_write(4'hc, 32'hffffffff, 4'hf);
		check("unmapped bresp", 32'(resp), 32'h2);
		axi_read(4'hc);
		check("unmapped rresp", 32'(resp), 32'h2);
		check("unmapped rdata", rd, 32'h0);
		$display("test clock config done");
	endtask

	task automatic t_switch(input logic [1:0] sel, input logic [31:0] exp);
		// Read lands while the switch runs, so it must wait for the new status
		fork
			axi_write(CLK_CFG_OFFSET, {30'h3fffff3c, sel}, 4'hf);
			begin
				repeat (2) @(posedge clk);
				axi_read(CLK_CFG_OFFSET);
			end
		join
		check("read during switch", rd, exp);
		for (int i = 0; i < 20 && switch_status !== sel; i++) begin
			@(posedge clk);
		end
		check("switch_status", 32'(switch_status), 32'(sel));
		axi_read(CLK_CFG_OFFSET);
		check("clock_configuration", rd, exp);
		$display("test switch done");
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		t_reset();
		t_pll_write();
		t_pll_lock();
		t_byte_write();
		t_clocks();
		t_clk_cfg();
		t_switch(2'h1, 32'hfffffcf5);
		t_switch(2'h2, 32'hfffffcfa);
		conclude();
	end

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end
endmodule
